// ---- bench/bridge_reset_strap_control_test.sv ----
// self-checking bench joining the bridge end and the board end
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module bridge_reset_strap_control_test;
    import bridge_pkg::*;
    localparam int FMIN = 4;
    logic        clk_i, rst_i, cyc, stb, we, db, hm, bt, wd, chr, phr;
    logic        ack, irq, pbr, bpo, fr, wdo, ca;
    logic [3:0]  ci;
    logic [15:0] adr;
    logic [31:0] dat, rd, seed;
    logic [31:0] q[$];
    int          checked, n_mismatch;
    bridge_link_if lk();
    bridge_dev bridge_dev_i (.clk_i, .rst_i, .link(lk), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq),
        .doorbell_i(db), .pb_if_reset_o(pbr), .boot_from_procbus_o(bpo),
        .wide_request_drive_o(wdo));
    bridge_brd #(.FULL_MIN_CYC(FMIN)) bridge_brd_i (.clk_i, .rst_i,
        .link(lk), .host_mode_i(hm), .cpu_hard_reset_i(chr),
        .pci_host_reset_i(phr), .boot_from_procbus_i(bt),
        .wide_request_drive_i(wd), .cfg_addr_line_i(ca),
        .cpu_full_reset_o(fr), .cpu_irq_in_o(ci));
    link_sva chk_i (.clk_i, .rst_i, .pb_if_reset_o(pbr),
        .pci_reset_dir_strap(lk.pci_reset_dir_strap),
        .procbus_reset_dir_strap(lk.procbus_reset_dir_strap),
        .procbus_reset_n(lk.procbus_reset_n), .irq_dev_oe(lk.irq_dev_oe),
        .pci_primary_reset_n(lk.pci_primary_reset_n),
        .pci_primary_reset_dev_oe(lk.pci_primary_reset_dev_oe),
        .procbus_reset_dev_oe(lk.procbus_reset_dev_oe),
        .wide_transfer_request_n(lk.wide_transfer_request_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic wb(input logic [15:0] a, input logic w,
                      input logic [31:0] d);
        if (!w) q.push_back(d);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        for (int k = 0; k < 50 && ack !== 1'b1; k++) @(posedge clk_i);
        `CHK("ack", 1'b1, ack)
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        stop_test();
    end
    // read data is judged where ack is sampled, oldest note first
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            `CHK("rdata", q[0], rd)
            void'(q.pop_front());
        end
    end
    initial begin
        {cyc, stb, we, db, chr, phr, ca, adr, dat} = '0;
        {rst_i, hm, bt, wd, seed} = {4'hF, 32'h52};
        for (int m = 1; m >= 0; m--) begin
            {rst_i, hm, bt, wd} <= {1'b1, {3{m[0]}}};
            repeat (16) @(posedge clk_i);
            rst_i <= 1'b0;
            @(posedge clk_i);
            seed = xs(seed);
            ca   <= seed[7];
            wb(IRQ_DIR_OFS, 0, 32'h0);
            wb(IRQ_DIR_OFS, 1, {26'h0, seed[5:0] | 6'h05});
            wb(IRQ_DIR_OFS, 0, {26'h0, seed[5:0] | 6'h05});
            wb(16'h0500, 0, 32'h0);
            wb(STRAP_OFS, 0, m ? 32'h1D : 32'h12);
            `CHK("boot", m[0], bpo)
            `CHK("wdrv", m[0], wdo)
            `CHK("sel", m[0] ? 1'b0 : ca, lk.config_select_in)
            wb(MASK_OFS, 1, m ? 32'h2 : 32'h1);
            wb(STATUS_OFS, 1, 32'h7);
            {chr, phr} <= {m[0], !m[0]};
            repeat (10) @(posedge clk_i);
            `CHK("pb", 3'h3, {lk.procbus_reset_n, pbr, irq})
            `CHK("wide", !m[0], lk.wide_transfer_request_n)
            `CHK("sec", 1'b0, lk.pci_secondary_reset_n)
            {chr, phr} <= 2'b00;
            repeat (10) @(posedge clk_i);
            wb(STATUS_OFS, 1, 32'h7);
            @(posedge clk_i);
            `CHK("rel", 3'h1, {pbr, irq, lk.pci_secondary_reset_n})
            wb(DOORBELL_OFS, 1, 32'h0);
            db <= 1'b1;
            @(posedge clk_i);
            db <= 1'b0;
            repeat (6) @(posedge clk_i);
            `CHK("cpu irq", {3'h0, m[0]}, ci)
            wb(DOORBELL_OFS, 1, 32'h2);
            wb(DOORBELL_OFS, 0, 32'h102);
            // the latch must outlive the pin, so look after the minimum
            for (int k = 0; k < 20 && fr !== 1'b1; k++) @(posedge clk_i);
            repeat (FMIN) @(posedge clk_i);
            `CHK("full", 1'b1, fr)
            wb(DOORBELL_OFS, 1, 32'h102);
            repeat (8) @(posedge clk_i);
            `CHK("full", 1'b0, fr)
            $display("mode %0d test done", m);
        end
        stop_test();
    end
endmodule : bridge_reset_strap_control_test

// ---- bench/link_sva.sv ----
// assertions on the pins between the bridge end and the board end
`timescale 1ns/1ps
module link_sva (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       pci_reset_dir_strap,
    input wire logic       procbus_reset_dir_strap,
    input wire logic       procbus_reset_n,
    input wire logic       pci_primary_reset_n,
    input wire logic       pci_primary_reset_dev_oe,
    input wire logic       procbus_reset_dev_oe,
    input wire logic       wide_transfer_request_n,
    input wire logic       pb_if_reset_o,
    input wire logic [5:0] irq_dev_oe
);
    // pins cross two sync flops and an output flop, hence the run lengths
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    property p_host; (pci_reset_dir_strap && !procbus_reset_n) [*5]
        |-> !pci_primary_reset_n; endproperty
    a_host: assert property (p_host) else $error("pci reset high");
    property p_perip; (!pci_reset_dir_strap && !pci_primary_reset_n) [*5]
        |-> !procbus_reset_n; endproperty
    a_perip: assert property (p_perip) else $error("no propagate");
    property p_pdir; (!pci_reset_dir_strap) [*5]
        |-> !pci_primary_reset_dev_oe; endproperty
    a_pdir: assert property (p_pdir) else $error("pci driven");
    property p_bdir; (!procbus_reset_dir_strap) [*5]
        |-> !procbus_reset_dev_oe; endproperty
    a_bdir: assert property (p_bdir) else $error("procbus driven");
    property p_wide; !wide_transfer_request_n
        |-> !pci_primary_reset_n || !$past(pci_primary_reset_n); endproperty
    a_wide: assert property (p_wide) else $error("wide out of reset");
    property p_mon; (!procbus_reset_n) [*4] |-> pb_if_reset_o; endproperty
    a_mon: assert property (p_mon) else $error("if not in reset");
    property p_run; procbus_reset_n [*6] |-> !pb_if_reset_o; endproperty
    a_run: assert property (p_run) else $error("if stuck in reset");
    property p_tri; (!procbus_reset_n) [*4] |-> irq_dev_oe == 6'h00;
    endproperty
    a_tri: assert property (p_tri) else $error("irq driven");
endmodule : link_sva

// ---- rtl/bridge_brd.sv ----
// board end: straps, power-on reset, reset routing, full reset latch
`timescale 1ns/1ps
module bridge_brd #(
    parameter int RST_PIN      = 2,
    parameter int CPU_IRQ_SEL  = 0,
    parameter int FULL_MIN_CYC = bridge_pkg::FULL_RST_MIN_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    bridge_link_if.brd      link,
    input  wire logic       host_mode_i,
    input  wire logic       cpu_hard_reset_i,
    input  wire logic       pci_host_reset_i,
    input  wire logic       boot_from_procbus_i,
    input  wire logic       wide_request_drive_i,
    input  wire logic       cfg_addr_line_i,
    output logic            cpu_full_reset_o,
    output logic [3:0]      cpu_irq_in_o
);
    import bridge_pkg::*;

    // ------------------------------------------------------------
    // straps and power-on reset
    // ------------------------------------------------------------
    logic       por_hold;
    logic [7:0] hold_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.power_on_reset_in_n <= 1'b0;
        end else begin
            link.power_on_reset_in_n <=
                !(host_mode_i && cpu_hard_reset_i);
        end
    end

    // option pins stay driven through the release plus the hold time
    always_ff @(posedge clk_i) begin
        if (rst_i || !link.power_on_reset_in_n) begin
            hold_cnt_reg <= 8'(STRAP_HOLD_CYC);
        end else if (hold_cnt_reg != 8'h00) begin
            hold_cnt_reg <= hold_cnt_reg - 8'h01;
        end
    end

    assign por_hold = !link.power_on_reset_in_n || hold_cnt_reg != 8'h00;

    assign link.pci_reset_dir_strap     = host_mode_i;
    assign link.procbus_reset_dir_strap = !host_mode_i;
    assign link.config_select_in = !host_mode_i && cfg_addr_line_i;

    always_comb begin
        link.irq_brd_oe           = 6'h00;
        link.irq_brd_o            = 6'h3F;
        link.irq_brd_oe[PIN_BOOT] = por_hold;
        link.irq_brd_o[PIN_BOOT]  = boot_from_procbus_i;
        link.irq_brd_oe[PIN_WIDE] = por_hold;
        link.irq_brd_o[PIN_WIDE]  = !wide_request_drive_i;
        link.irq_brd_oe[PIN_MUX]  = por_hold;
        link.irq_brd_o[PIN_MUX]   = 1'b1;
    end

    // ------------------------------------------------------------
    // reset routing
    // ------------------------------------------------------------
    assign link.procbus_reset_brd_oe     = cpu_hard_reset_i;
    assign link.procbus_reset_brd_o      = 1'b0;
    assign link.pci_primary_reset_brd_oe = !host_mode_i;
    assign link.pci_primary_reset_brd_o  = !pci_host_reset_i;
    assign link.pci_irq_a_brd_oe         = 1'b0;
    assign link.pci_irq_a_brd_o          = 1'b1;

    // ------------------------------------------------------------
    // interrupt pin synchroniser and processor interrupt routing
    // ------------------------------------------------------------
    logic [5:0] irq_meta_reg;
    logic [5:0] irq_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_meta_reg <= 6'h3F;
            irq_sync_reg <= 6'h3F;
        end else begin
            irq_meta_reg <= link.irq_n;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_in_o <= 4'h0;
        end else begin
            cpu_irq_in_o <= 4'h0;
            cpu_irq_in_o[CPU_IRQ_SEL] <=
                host_mode_i && !irq_sync_reg[PIN_ROUTE];
        end
    end

    // ------------------------------------------------------------
    // full reset latch
    // ------------------------------------------------------------
    // the pin floats high once the bridge enters reset, so the latch
    // keeps the request on its own counter for the minimum time, then waits for the pin to go high
    latch_state_t state_reg;
    logic [15:0]  full_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= LATCH_IDLE;
            full_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                LATCH_IDLE: begin
                    if (!irq_sync_reg[RST_PIN]) begin
                        state_reg    <= LATCH_HOLD;
                        full_cnt_reg <= 16'(FULL_MIN_CYC - 1);
                    end
                end
                LATCH_HOLD: begin
                    if (full_cnt_reg == 16'h0000) begin
                        state_reg <= LATCH_WAIT;
                    end else begin
                        full_cnt_reg <= full_cnt_reg - 16'h0001;
                    end
                end
                LATCH_WAIT: begin
                    if (irq_sync_reg[RST_PIN]) begin
                        state_reg <= LATCH_IDLE;
                    end
                end
                default: begin
                    state_reg <= LATCH_IDLE;
                end
            endcase
        end
    end

    assign cpu_full_reset_o = state_reg != LATCH_IDLE;
endmodule : bridge_brd

// ---- rtl/bridge_dev.sv ----
// bridge end: reset propagation, strap capture, interrupt pins
`timescale 1ns/1ps
module bridge_dev #(
    parameter bit DUAL_PCI = 1'b1
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    bridge_link_if.dev                        link,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [bridge_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    output logic                              irq_o,
    input  wire logic                         doorbell_i,
    output logic                              pb_if_reset_o,
    output logic                              boot_from_procbus_o,
    output logic                              wide_request_drive_o
);
    import bridge_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [11:0] pin_raw;
    logic [11:0] pin_meta_reg;
    logic [11:0] pin_sync_reg;
    logic        por_s;
    logic        pci_strap_s;
    logic        pb_strap_s;
    logic        pb_s;
    logic        prim_s;
    logic [5:0]  irq_s;
    logic        irqa_s;

    assign pin_raw = {link.pci_irq_a_n, link.irq_n, link.pci_primary_reset_n,
                      link.procbus_reset_n, link.procbus_reset_dir_strap,
                      link.pci_reset_dir_strap, link.power_on_reset_in_n};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= 12'hFFF;
            pin_sync_reg <= 12'hFFF;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {irqa_s, irq_s, prim_s, pb_s, pb_strap_s, pci_strap_s, por_s} =
        pin_sync_reg;

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    // straps track the pins while power-on reset is low and freeze at
    // its release; later interrupt traffic cannot change the mode
    logic [4:0] strap_reg;
    logic       host_mode;
    logic       pb_out_mode;
    logic       wide_en;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_reg <= 5'h00;
        end else if (!por_s) begin
            strap_reg[SP_PCI_DIR]  <= pci_strap_s;
            strap_reg[SP_PB_DIR]   <= pb_strap_s;
            strap_reg[SP_BOOT_PB]  <= irq_s[PIN_BOOT];
            strap_reg[SP_WIDE_EN]  <= !irq_s[PIN_WIDE];
            strap_reg[SP_MUX_MODE] <= irq_s[PIN_MUX];
        end
    end

    assign host_mode            = strap_reg[SP_PCI_DIR];
    assign pb_out_mode          = strap_reg[SP_PB_DIR];
    assign wide_en              = strap_reg[SP_WIDE_EN];
    assign boot_from_procbus_o  = strap_reg[SP_BOOT_PB];
    assign wide_request_drive_o = wide_en;

    // ------------------------------------------------------------
    // reset propagation
    // ------------------------------------------------------------
    logic pb_reset_in;
    logic prim_assert;
    logic pb_assert;

    assign pb_reset_in = !pb_s || !por_s;
    assign prim_assert = host_mode && pb_reset_in;
    assign pb_assert   = host_mode ? !por_s : !prim_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.pci_primary_reset_dev_oe <= 1'b0;
            link.pci_primary_reset_dev_o  <= 1'b1;
            link.procbus_reset_dev_oe     <= 1'b0;
            link.procbus_reset_dev_o      <= 1'b0;
            link.pci_secondary_reset_n    <= 1'b0;
            link.wide_transfer_request_oe <= 1'b0;
            link.wide_transfer_request_o  <= 1'b0;
            pb_if_reset_o                 <= 1'b1;
        end else begin
            link.pci_primary_reset_dev_oe <= host_mode;
            link.pci_primary_reset_dev_o  <= !prim_assert;
            // open-drain style so the pin can still be pulled low
            // from outside and seen by the monitor below
            link.procbus_reset_dev_oe     <= pb_out_mode && pb_assert;
            link.procbus_reset_dev_o      <= 1'b0;
            // single-port parts keep the unused bus in reset
            link.pci_secondary_reset_n    <= DUAL_PCI &&
                !(host_mode ? prim_assert : !prim_s);
            link.wide_transfer_request_oe <= wide_en && prim_assert;
            link.wide_transfer_request_o  <= 1'b0;
            pb_if_reset_o                 <= pb_reset_in;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [5:0] dir_reg;
    logic [2:0] status_reg;
    logic [2:0] mask_reg;
    logic [2:0] db_sel_reg;
    logic       db_act_reg;
    logic       prim_d_reg;
    logic       pb_d_reg;
    logic [2:0] events;
    logic       wr;
    logic       rd_req;

    // a write lands on the edge where the master sees ack, not before
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                    wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prim_d_reg <= 1'b1;
            pb_d_reg   <= 1'b1;
        end else begin
            prim_d_reg <= prim_s;
            pb_d_reg   <= pb_reset_in;
        end
    end

    assign events[ST_PRIM_RST] = prim_d_reg && !prim_s;
    assign events[ST_PROCBUS_RESET]   = !pb_d_reg && pb_reset_in;
    assign events[ST_DOORBELL] = doorbell_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_reg <= IRQ_DIR_RST;
        end else if (wr && wb_adr_i == IRQ_DIR_OFS) begin
            dir_reg <= wb_dat_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= MASK_RST;
        end else if (wr && wb_adr_i == MASK_OFS) begin
            mask_reg <= wb_dat_i[2:0];
        end
    end

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= 3'h0;
        end else if (wr && wb_adr_i == STATUS_OFS) begin
            status_reg <= (status_reg & ~wb_dat_i[2:0]) | events;
        end else begin
            status_reg <= status_reg | events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // doorbell stays active until software clears it, so the board
    // latch sees it even if the pin is tristated a little later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            db_sel_reg <= 3'h0;
            db_act_reg <= 1'b0;
        end else begin
            if (wr && wb_adr_i == DOORBELL_OFS) begin
                db_sel_reg <= wb_dat_i[DB_SEL_LSB +: 3];
            end
            if (doorbell_i) begin
                db_act_reg <= 1'b1;
            end else if (wr && wb_adr_i == DOORBELL_OFS &&
                         wb_dat_i[DB_CLR_BIT]) begin
                db_act_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: ack one cycle after the request
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= rd_req;
            if (rd_req) begin
                if (wb_adr_i == IRQ_DIR_OFS) begin
                    wb_dat_o <= {26'h0, dir_reg};
                end else if (wb_adr_i == STATUS_OFS) begin
                    wb_dat_o <= {29'h0, status_reg};
                end else if (wb_adr_i == MASK_OFS) begin
                    wb_dat_o <= {29'h0, mask_reg};
                end else if (wb_adr_i == STRAP_OFS) begin
                    wb_dat_o <= {27'h0, strap_reg};
                end else if (wb_adr_i == DOORBELL_OFS) begin
                    wb_dat_o <= {23'h0, db_act_reg, 5'h0, db_sel_reg};
                end else begin
                    wb_dat_o <= 32'h0000_0000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt pins
    // ------------------------------------------------------------
    logic [5:0] irq_src;
    logic       irqa_src;

    generate
        for (genvar i = 0; i < NUM_INT; i++) begin : g_pin
            assign irq_src[i] =
                (db_act_reg && db_sel_reg == 3'(i)) ||
                (i == PIN_ROUTE && host_mode && !irqa_s);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    link.irq_dev_oe[i] <= 1'b0;
                    link.irq_dev_o[i]  <= 1'b1;
                end else begin
                    // released during procbus reset and power-on reset
                    link.irq_dev_oe[i] <= dir_reg[i] &&
                        !pb_reset_in;
                    link.irq_dev_o[i]  <= !irq_src[i];
                end
            end
        end
    endgenerate

    assign irqa_src = !host_mode && |(~dir_reg[1:0] & ~irq_s[1:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.pci_irq_a_dev_oe <= 1'b0;
        end else begin
            link.pci_irq_a_dev_oe <= irqa_src;
        end
    end

    assign link.pci_irq_a_dev_o = 1'b0;
endmodule : bridge_dev

// ---- rtl/bridge_link_if.sv ----
// board-level pins between the bridge and its board logic
`timescale 1ns/1ps
interface bridge_link_if;
    logic                 power_on_reset_in_n;
    logic                 pci_reset_dir_strap;
    logic                 procbus_reset_dir_strap;
    logic                 config_select_in;
    logic                 procbus_reset_dev_o;
    logic                 procbus_reset_dev_oe;
    logic                 procbus_reset_brd_o;
    logic                 procbus_reset_brd_oe;
    logic                 pci_primary_reset_dev_o;
    logic                 pci_primary_reset_dev_oe;
    logic                 pci_primary_reset_brd_o;
    logic                 pci_primary_reset_brd_oe;
    logic                 pci_secondary_reset_n;
    logic [5:0]           irq_dev_o;
    logic [5:0]           irq_dev_oe;
    logic [5:0]           irq_brd_o;
    logic [5:0]           irq_brd_oe;
    logic                 pci_irq_a_dev_o;
    logic                 pci_irq_a_dev_oe;
    logic                 pci_irq_a_brd_o;
    logic                 pci_irq_a_brd_oe;
    logic                 wide_transfer_request_o;
    logic                 wide_transfer_request_oe;
    // resolved pin levels; every pin is pulled up when nobody pulls low
    logic                 procbus_reset_n;
    logic                 pci_primary_reset_n;
    logic [5:0]           irq_n;
    logic                 pci_irq_a_n;
    logic                 wide_transfer_request_n;

    assign procbus_reset_n =
        !((procbus_reset_dev_oe && !procbus_reset_dev_o) ||
          (procbus_reset_brd_oe && !procbus_reset_brd_o));
    assign pci_primary_reset_n =
        !((pci_primary_reset_dev_oe && !pci_primary_reset_dev_o) ||
          (pci_primary_reset_brd_oe && !pci_primary_reset_brd_o));
    assign irq_n = ~((irq_dev_oe & ~irq_dev_o) | (irq_brd_oe & ~irq_brd_o));
    assign pci_irq_a_n =
        !((pci_irq_a_dev_oe && !pci_irq_a_dev_o) ||
          (pci_irq_a_brd_oe && !pci_irq_a_brd_o));
    assign wide_transfer_request_n =
        !(wide_transfer_request_oe && !wide_transfer_request_o);

    modport dev (
        input  power_on_reset_in_n, pci_reset_dir_strap,
        input  procbus_reset_dir_strap, config_select_in,
        input  procbus_reset_n, pci_primary_reset_n, irq_n, pci_irq_a_n,
        output procbus_reset_dev_o, procbus_reset_dev_oe,
        output pci_primary_reset_dev_o, pci_primary_reset_dev_oe,
        output pci_secondary_reset_n, irq_dev_o, irq_dev_oe,
        output pci_irq_a_dev_o, pci_irq_a_dev_oe,
        output wide_transfer_request_o, wide_transfer_request_oe
    );
    modport brd (
        output power_on_reset_in_n, pci_reset_dir_strap,
        output procbus_reset_dir_strap, config_select_in,
        output procbus_reset_brd_o, procbus_reset_brd_oe,
        output pci_primary_reset_brd_o, pci_primary_reset_brd_oe,
        output irq_brd_o, irq_brd_oe, pci_irq_a_brd_o, pci_irq_a_brd_oe,
        input  procbus_reset_n, pci_primary_reset_n, irq_n, pci_irq_a_n,
        input  wide_transfer_request_n, pci_secondary_reset_n
    );
endinterface : bridge_link_if

// ---- rtl/bridge_pkg.sv ----
// constants and types shared by both ends of the reset and strap link
// ------------------------------------------------------------------
// How it works
// - host mode: processor reset drives PCI resets low
// - board holds option pins during each power-on reset
// - PCI reset strap: high drives, low propagates
// - procbus strap: low processor drives, high bridge drives
// - peripheral: PCI reset asserts procbus and secondary reset
// - bridge always monitors procbus reset pin
// - procbus reset follows processor hard reset
// - config select tied low or to address line
// - interrupt pin 3 selects boot source
// - interrupt pin 4 low enables wide request drive
// - board keeps interrupt pin 1 high at release
// - interrupt pin directions set per pin by register
// - interrupt routing depends on mode
// - routed interrupt uses one of four processor inputs
// - external latch drives processor full reset
// - latch holds; bridge tristates interrupts in reset
// - doorbell input asserts mapped interrupt
// - PCI host supplies primary reset in peripheral mode
// ------------------------------------------------------------------
package bridge_pkg;
    localparam int NUM_INT = 6;
    localparam int ADR_W   = 16;

    // register byte addresses
    localparam logic [15:0] IRQ_DIR_OFS  = 16'h0444;
    localparam logic [15:0] STATUS_OFS   = 16'h0448;
    localparam logic [15:0] MASK_OFS     = 16'h044C;
    localparam logic [15:0] STRAP_OFS    = 16'h0450;
    localparam logic [15:0] DOORBELL_OFS = 16'h0454;

    // values after reset
    localparam logic [5:0] IRQ_DIR_RST = 6'h00;
    localparam logic [2:0] MASK_RST    = 3'h0;

    // status and mask bit positions
    localparam int ST_PRIM_RST = 0;
    localparam int ST_PROCBUS_RESET   = 1;
    localparam int ST_DOORBELL = 2;

    // strap register bit positions
    localparam int SP_PCI_DIR  = 0;
    localparam int SP_PB_DIR   = 1;
    localparam int SP_BOOT_PB  = 2;
    localparam int SP_WIDE_EN  = 3;
    localparam int SP_MUX_MODE = 4;

    // doorbell register fields
    localparam int DB_SEL_LSB = 0;
    localparam int DB_CLR_BIT = 8;
    localparam int DB_ACT_BIT = 8;

    // interrupt routing pin, and interrupt pins that double as power-up options
    localparam int PIN_ROUTE = 0;
    localparam int PIN_MUX   = 1;
    localparam int PIN_BOOT  = 3;
    localparam int PIN_WIDE  = 4;

    // timing
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int STRAP_HOLD_NS  = 10;
    localparam int STRAP_HOLD_CYC =
        (STRAP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FULL_RST_MIN_CYC = 16;

    typedef enum logic [1:0] {
        LATCH_IDLE,
        LATCH_HOLD,
        LATCH_WAIT
    } latch_state_t;
endpackage : bridge_pkg
